// >>> rtl/cbps_sequencer.sv
// Top of the bias pulse sequencer: phase decode and pulse outputs.
`timescale 1ns/1ps
`default_nettype none
module cbps_sequencer
	import cbps_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hSync,
	input wire logic vRetrace,
	output logic autoBiasPulse,
	output logic gridPulse,
	output logic programPulse
);

	cbps_line_if lineLink ();

	cbps_phase_t phase;
	logic autoBias_r;
	logic autoBias_nxt;
	logic grid_r;
	logic grid_nxt;
	logic program_r;
	logic program_nxt;
	logic [CBPS_CNT_W-1:0] line;

	////////////////////////////////////////////////////////////////////////
	// Line counting lives in its own module so the phase decode below
	// only ever sees a clean, already framed count.
	cbps_line_counter counter (
		.clk(clk),
		.rst_b(rst_b),
		.hSync(hSync),
		.vRetrace(vRetrace),
		.link(lineLink.counter)
	);

	assign line = lineLink.lineCount;

	////////////////////////////////////////////////////////////////////////
	// Phase decode from the line number. Decoding from the count rather
	// than stepping phases keeps the sequence self-correcting if a field
	// is cut short by a new retrace.
	always_comb begin
		phase = CBPS_PH_IDLE;
		if (lineLink.seqActive) begin
			if (line <= CBPS_QUIET_LINES) begin
				phase = CBPS_PH_QUIET;
			end else if (line < CBPS_SETUP_LINE) begin
				phase = CBPS_PH_BLACK;
			end else if (line < CBPS_MEASURE_LINE) begin
				phase = CBPS_PH_SETUP;
			end else if (line < CBPS_END_LINE) begin
				phase = CBPS_PH_MEASURE;
			end
		end
	end

	// Pulse levels for each phase; idle covers the end of the cycle.
	always_comb begin
		autoBias_nxt = CBPS_AUTO_BIAS_IDLE;
		grid_nxt = CBPS_GRID_IDLE;
		program_nxt = CBPS_PROGRAM_IDLE;
		case (phase)
			CBPS_PH_IDLE: begin
				autoBias_nxt = CBPS_AUTO_BIAS_IDLE;
			end
			CBPS_PH_QUIET: begin
				autoBias_nxt = CBPS_AUTO_BIAS_IDLE;
			end
			CBPS_PH_BLACK: begin
				autoBias_nxt = 1'b1;
			end
			CBPS_PH_SETUP: begin
				autoBias_nxt = 1'b1;
				grid_nxt = 1'b0;
				program_nxt = 1'b1;
			end
			CBPS_PH_MEASURE: begin
				autoBias_nxt = 1'b1;
				grid_nxt = 1'b1;
				program_nxt = 1'b0;
			end
			default: begin
				autoBias_nxt = CBPS_AUTO_BIAS_IDLE;
			end
		endcase
	end

	// Registers only; outputs come straight from these flip-flops.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			autoBias_r <= CBPS_AUTO_BIAS_IDLE;
			grid_r <= CBPS_GRID_IDLE;
			program_r <= CBPS_PROGRAM_IDLE;
		end else begin
			autoBias_r <= autoBias_nxt;
			grid_r <= grid_nxt;
			program_r <= program_nxt;
		end
	end

	assign autoBiasPulse = autoBias_r;
	assign gridPulse = grid_r;
	assign programPulse = program_r;

endmodule
`default_nettype wire

// >>> rtl/cbps_pkg.sv
// Constants and types shared by the bias pulse sequencer files.
// Behaviour
// - In each retrace interval, count line syncs; the first thirteen change no output.
// - On the fourteenth line sync, raise the auto-bias pulse.
// - Auto-bias pulse stays high exactly seven line periods, then falls.
// - Fifteenth line sync starts setup: grid pulse low, program pulse high.
// - Setup lasts exactly three line periods before measurement.
// - On the eighteenth line sync, raise the grid pulse.
// - With the grid pulse rising, drive the program pulse low.
package cbps_pkg;

	localparam int CBPS_CNT_W = 5;
	localparam logic [CBPS_CNT_W-1:0] CBPS_CNT_RESET = 5'h00;
	localparam logic [CBPS_CNT_W-1:0] CBPS_CNT_ONE = 5'h01;
	// Line numbers count from one: the first sync of the field is line 1.
	localparam logic [CBPS_CNT_W-1:0] CBPS_QUIET_LINES = 5'h0d;
	localparam logic [CBPS_CNT_W-1:0] CBPS_BLACK_LINE = 5'h0e;
	localparam logic [CBPS_CNT_W-1:0] CBPS_BLACK_LINES = 5'h07;
	localparam logic [CBPS_CNT_W-1:0] CBPS_SETUP_LINE = 5'h0f;
	localparam logic [CBPS_CNT_W-1:0] CBPS_SETUP_LINES = 5'h03;
	localparam logic [CBPS_CNT_W-1:0] CBPS_MEASURE_LINE =
		CBPS_SETUP_LINE + CBPS_SETUP_LINES;
	localparam logic [CBPS_CNT_W-1:0] CBPS_END_LINE =
		CBPS_BLACK_LINE + CBPS_BLACK_LINES;

	// Idle and reset levels of the three pulse outputs.
	localparam logic CBPS_AUTO_BIAS_IDLE = 1'b0;
	localparam logic CBPS_GRID_IDLE = 1'b0;
	localparam logic CBPS_PROGRAM_IDLE = 1'b1;

	typedef enum logic [2:0] {
		CBPS_PH_IDLE,
		CBPS_PH_QUIET,
		CBPS_PH_BLACK,
		CBPS_PH_SETUP,
		CBPS_PH_MEASURE
	} cbps_phase_t;

endpackage

// >>> rtl/cbps_line_if.sv
// Interface carrying the line count from the counter to the sequencer.
`timescale 1ns/1ps
`default_nettype none
interface cbps_line_if;
	import cbps_pkg::*;
	logic [CBPS_CNT_W-1:0] lineCount;
	logic seqActive;

	modport counter (output lineCount, output seqActive);
	modport seq (input lineCount, input seqActive);
endinterface
`default_nettype wire

// >>> rtl/cbps_line_counter.sv
// Line sync counter, framed by the retrace input.
`timescale 1ns/1ps
`default_nettype none
module cbps_line_counter
	import cbps_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hSync,
	input wire logic vRetrace,
	cbps_line_if.counter link
);

	logic hSyncPrev_r;
	logic hSyncPrev_nxt;
	logic vRetracePrev_r;
	logic vRetracePrev_nxt;
	logic active_r;
	logic active_nxt;
	logic [CBPS_CNT_W-1:0] count_r;
	logic [CBPS_CNT_W-1:0] count_nxt;
	logic syncEdge;
	logic fieldStart;

	////////////////////////////////////////////////////////////////////////
	// Edge detection and counting. A retrace start wins over a sync edge
	// in the same cycle, so that edge is not counted. Counting runs on
	// past the end of retrace until the sequence is finished, because the
	// retrace may be shorter than the whole sequence.
	always_comb begin
		hSyncPrev_nxt = hSync;
		vRetracePrev_nxt = vRetrace;
		syncEdge = hSync && !hSyncPrev_r;
		fieldStart = vRetrace && !vRetracePrev_r;
		active_nxt = active_r;
		count_nxt = count_r;
		if (fieldStart) begin
			active_nxt = 1'b1;
			count_nxt = CBPS_CNT_RESET;
		end else if (active_r && syncEdge) begin
			count_nxt = count_r + CBPS_CNT_ONE;
			if (count_nxt == CBPS_END_LINE) begin
				active_nxt = 1'b0;
			end
		end
	end

	// Registers only; the edge memories start low, so an input already high at reset release counts as an edge.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hSyncPrev_r <= 1'b0;
			vRetracePrev_r <= 1'b0;
			active_r <= 1'b0;
			count_r <= CBPS_CNT_RESET;
		end else begin
			hSyncPrev_r <= hSyncPrev_nxt;
			vRetracePrev_r <= vRetracePrev_nxt;
			active_r <= active_nxt;
			count_r <= count_nxt;
		end
	end

	assign link.lineCount = count_r;
	assign link.seqActive = active_r;

endmodule
`default_nettype wire

// >>> verif/cbps_chroma_model.sv
// Companion chroma model: its drive is held at black during auto-bias.
`timescale 1ns/1ps
`default_nettype none
module cbps_chroma_model (
	input wire logic autoBiasPulse,
	output logic rgbBlack
);
	assign rgbBlack = autoBiasPulse;
endmodule
`default_nettype wire

// >>> verif/cbps_sequencer_sva.sv
// Concurrent checks on the bias pulse outputs.
`timescale 1ns/1ps
`default_nettype none
module cbps_sequencer_sva (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic hSync,
	input wire logic vRetrace,
	input wire logic autoBiasPulse,
	input wire logic gridPulse,
	input wire logic programPulse
);
	logic [4:0] cnt_r;
	logic hPrev_r;
	logic vPrev_r;
	// Line count; 21 means disarmed, so stray syncs cannot restart it.
	// Edges come from held copies, so the helper needs no sampled calls.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= 5'h15;
			hPrev_r <= 1'b0;
			vPrev_r <= 1'b0;
		end else begin
			hPrev_r <= hSync;
			vPrev_r <= vRetrace;
			if (vRetrace && !vPrev_r) begin
				cnt_r <= 5'h00;
			end else if (cnt_r != 5'h15 && hSync && !hPrev_r) begin
				cnt_r <= cnt_r + 5'h01;
			end
		end
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// The pulses register one edge after the count, hence a depth of one.
	quiet_idle_a: assert property ($past(cnt_r) < 5'h0e |->
		!autoBiasPulse && !gridPulse) else $error("early pulse");
	bias_start_a: assert property ($past(cnt_r) == 5'h0e |->
		autoBiasPulse) else $error("bias pulse late");
	bias_span_a: assert property (autoBiasPulse ==
		($past(cnt_r) inside {[5'h0e:5'h14]})) else $error("bias span");
	setup_level_a: assert property ($past(cnt_r) inside
		{[5'h0f:5'h11]} |-> !gridPulse && programPulse) else $error("setup");
	// Only the first cycle of line 18 expects the rise itself.
	grid_rise_a: assert property ($past(cnt_r) == 5'h12 &&
		$past(cnt_r, 2) != 5'h12 |-> $rose(gridPulse))
		else $error("grid pulse late");
	prog_low_a: assert property ($rose(gridPulse) |->
		$fell(programPulse)) else $error("program pulse stuck");
	idle_restore_a: assert property ($past(cnt_r) == 5'h15 |->
		!gridPulse && programPulse) else $error("not idle");
	field_clear_a: assert property ($rose(vRetrace) |-> ##3
		!autoBiasPulse && !gridPulse) else $error("no restart");
endmodule
bind cbps_sequencer cbps_sequencer_sva chk (.clk(clk), .rst_b(rst_b),
	.hSync(hSync), .vRetrace(vRetrace), .autoBiasPulse(autoBiasPulse),
	.gridPulse(gridPulse), .programPulse(programPulse));
`default_nettype wire

// >>> verif/cbps_sequencer_tb.sv
// Self-checking bench for the bias pulse sequencer.
`timescale 1ns/1ps
`default_nettype none
module cbps_sequencer_tb;
	logic clk = 1'b0, rst_b = 1'b0, hSync = 1'b0, vRetrace = 1'b0;
	logic ab, gp, pp, blk;
	int errors = 0, cmp_count = 0;
	cbps_sequencer uut (.clk(clk), .rst_b(rst_b), .hSync(hSync),
		.vRetrace(vRetrace), .autoBiasPulse(ab), .gridPulse(gp),
		.programPulse(pp));
	cbps_chroma_model chroma (.autoBiasPulse(ab), .rgbBlack(blk));
	initial forever #25 clk = ~clk;
	// The run needs some 300 cycles, so 3000 can only mean a hang.
	initial begin
		repeat (3000) @(posedge clk);
		errors++;
		end_sim();
	end
	task automatic end_sim();
		if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Looked at 1 ns after the edge, once the outputs have settled.
	task automatic check(input logic a, input logic g);
		#1 cmp_count++;
		if ({ab, blk, gp, pp} !== {a, a, g, !g}) begin
			errors++;
			$display("mismatch pulses exp %b%b seen %b%b%b%b",
				a, g, ab, blk, gp, pp);
		end
	endtask
	// Inputs rise together; two low cycles follow so every rise is clean.
	task automatic pulse(input logic v, input logic s);
		@(posedge clk) {vRetrace, hSync} <= {v, s};
		repeat (2) @(posedge clk);
		{vRetrace, hSync} <= 2'h0;
		repeat (2) @(posedge clk);
	endtask
	task automatic full_field();
		pulse(1'b1, 1'b0);
		for (int k = 1; k <= 24; k++) begin
			pulse(1'b0, 1'b1);
			check(k inside {[14:20]},
				k inside {[18:20]});
		end
	endtask
	// Retrace in mid-measurement, then a sync on the retrace edge itself.
	task automatic restart();
		pulse(1'b1, 1'b0);
		repeat (19) pulse(1'b0, 1'b1);
		pulse(1'b1, 1'b1);
		repeat (13) pulse(1'b0, 1'b1);
		check(1'b0, 1'b0);
		pulse(1'b0, 1'b1);
		check(1'b1, 1'b0);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		full_field();
		restart();
		end_sim();
	end
endmodule
`default_nettype wire
